// [wdt_map.vh]
// Constants of the windowed watchdog: register offsets, field positions,
// reset values, key codes and timing figures.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// Register offsets on the plain register port
`define WDT_ADDR_W 4
`define WDT_ADDR_RSS 4'h0
`define WDT_ADDR_SO1 4'h1
`define WDT_ADDR_SO2 4'h2
`define WDT_ADDR_CNT 4'h3

// Service key codes, low byte of the documented 16-bit values
`define WDT_KEY_FIRST 8'h55
`define WDT_KEY_SECOND 8'haa

// system_options_one: timeout_select field
`define WDT_TSEL_HI 7
`define WDT_TSEL_LO 6
`define WDT_TSEL_RST 2'h3
`define WDT_TSEL_OFF 2'h0
`define WDT_TSEL_SHORT 2'h1
`define WDT_TSEL_MID 2'h2

// system_options_two: watchdog_clock_select and window_enable
`define WDT_CLKS_BIT 7
`define WDT_WIN_BIT 6
`define WDT_CLKS_RST 1'h0
`define WDT_WIN_RST 1'h0
`define WDT_CLKS_LPO 1'h0

// reset_source_status bits
`define WDT_RSS_POR_BIT 7
`define WDT_RSS_WDT_BIT 5

// Overflow exponents, low-power clock then bus clock
`define WDT_EXP_LPO_1 5'd5
`define WDT_EXP_LPO_2 5'd8
`define WDT_EXP_LPO_3 5'd10
`define WDT_EXP_BUS_1 5'd13
`define WDT_EXP_BUS_2 5'd16
`define WDT_EXP_BUS_3 5'd18

// Counter width holds the largest overflow count, 2^18
`define WDT_CNT_W 19
`define WDT_CNT_ONE 19'h00001
`define WDT_CNT_ZERO 19'h00000

// Window opens after three quarters: limit minus limit shifted by this
`define WDT_WIN_SHIFT 2

// Timing: bus clock rate and low-power clock period
`define WDT_CLK_KHZ 40000
`define WDT_LPO_PERIOD_US 1000
`define WDT_US_PER_MS 1000
`define WDT_LPO_DIV ((`WDT_LPO_PERIOD_US * `WDT_CLK_KHZ) / `WDT_US_PER_MS)
`define WDT_DIV_W 16

`endif

// [wdt_tick_div.v]
// Divider that makes the low-power watchdog tick as a one-cycle enable.
// Assumes the bus clock is the only clock; clear_i restarts the period.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_tick_div #(
  parameter DIV = `WDT_LPO_DIV,
  parameter CW = `WDT_DIV_W
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire clear_i,
  output reg tick_o
);

  localparam [CW-1:0] ZERO = {CW{1'b0}};
  localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};
  localparam [CW-1:0] LAST = DIV[CW-1:0] - ONE; // Cut on purpose; the divide fits CW bits

  reg [CW-1:0] phase;

  // Phase counter; a clear holds it at zero so the next tick is a full period away
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase <= ZERO;
      tick_o <= 1'b0;
    end else if (clear_i) begin
      phase <= ZERO;
      tick_o <= 1'b0;
    end else if (phase == LAST) begin
      phase <= ZERO;
      tick_o <= 1'b1;
    end else begin
      phase <= phase + ONE;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [wdt_watchdog_timer.v]
// Windowed watchdog_timer: service keys, write-once options, timeout and
// window checks, and a reset request pulse toward the system reset logic.
// Assumes rst_b_i is the system reset driven in answer to the request and
// por_b_i is power-on only; stop_i and debug_i arrive as asynchronous pins.
// Assumes one register strobe at a time, and a master that takes read data
// in the cycle after the read strobe; the port never inserts wait states.
// The slow watchdog tick is made here by dividing the bus clock, so no
// second clock domain exists inside the block.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_watchdog_timer #(
  parameter LPO_DIV = `WDT_LPO_DIV,
  parameter DW = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire por_b_i,
  input wire [`WDT_ADDR_W-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [DW-1:0] rdata_o,
  input wire stop_i,
  input wire debug_i,
  output reg wdt_reset_req_o
);

  localparam [DW-1:0] DZERO = {DW{1'b0}};

  // Overflow count for the selected clock and timeout
  // A disabled setting still maps to a limit here; the enable term keeps it
  // from firing, so the function needs no special case for it.
  function [`WDT_CNT_W-1:0] timeout_limit;
    input clks;
    input [1:0] tsel;
    reg [4:0] expo;
    begin
      expo = 5'd0;
      if (clks == `WDT_CLKS_LPO) begin
        if (tsel == `WDT_TSEL_SHORT)
          expo = `WDT_EXP_LPO_1;
        else if (tsel == `WDT_TSEL_MID)
          expo = `WDT_EXP_LPO_2;
        else
          expo = `WDT_EXP_LPO_3;
      end else begin
        if (tsel == `WDT_TSEL_SHORT)
          expo = `WDT_EXP_BUS_1;
        else if (tsel == `WDT_TSEL_MID)
          expo = `WDT_EXP_BUS_2;
        else
          expo = `WDT_EXP_BUS_3;
      end
      timeout_limit = `WDT_CNT_ONE << expo;
    end
  endfunction

  // Count at which the window opens: three quarters of the limit
  // Shift and subtract is exact because every limit is a power of two
  function [`WDT_CNT_W-1:0] window_open;
    input [`WDT_CNT_W-1:0] limit;
    begin
      window_open = limit - (limit >> `WDT_WIN_SHIFT);
    end
  endfunction

  // Stop and debug pins, two flops before any logic looks at them
  // Only the second flop feeds logic, so a metastable first stage stays
  // contained; the cost is two cycles of latency on entering a halt.
  reg stop_m;
  reg stop_s;
  reg debug_m;
  reg debug_s;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_m <= 1'b0;
      stop_s <= 1'b0;
      debug_m <= 1'b0;
      debug_s <= 1'b0;
    end else begin
      stop_m <= stop_i;
      stop_s <= stop_m;
      debug_m <= debug_i;
      debug_s <= debug_m;
    end
  end

  // Stop and debug are treated alike: either one halts the count
  wire halted = stop_s | debug_s;

  // Option fields, lock flags, counter and sequence state
  reg [1:0] timeout_select;
  reg watchdog_clock_select;
  reg window_enable;
  reg so1_locked;
  reg so2_locked;
  reg [`WDT_CNT_W-1:0] count;
  reg key_armed;
  reg fired;
  reg wdt_caused;
  reg por_seen;

  // Bus decode of writes
  wire wr_rss = wr_i && (addr_i == `WDT_ADDR_RSS);
  wire wr_so1 = wr_i && (addr_i == `WDT_ADDR_SO1);
  wire wr_so2 = wr_i && (addr_i == `WDT_ADDR_SO2);
  wire key_first = wr_rss && (wdata_i == `WDT_KEY_FIRST);
  wire key_second = wr_rss && (wdata_i == `WDT_KEY_SECOND);
  wire key_bad = wr_rss && !key_first && !key_second;

  // Low-power tick; held in phase zero while halted so counting restarts clean
  // A service does not restart the divider, so a slow-clock timeout may end
  // up to one tick period early; keeping bus decode out of the divider
  // was judged worth that small loss of margin.
  wire lpo_tick;
  wire lpo_clear = halted || (watchdog_clock_select != `WDT_CLKS_LPO);

  wdt_tick_div #(
    .DIV(LPO_DIV),
    .CW(`WDT_DIV_W)
  ) wdt_tick_div_inst (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(lpo_clear),
    .tick_o(lpo_tick)
  );

  // Derived timing for the current settings
  // The largest limit needs every counter bit; the count itself never
  // goes past limit minus one, so no carry is ever lost.
  wire enabled = (timeout_select != `WDT_TSEL_OFF);
  wire on_lpo = (watchdog_clock_select == `WDT_CLKS_LPO);
  wire [`WDT_CNT_W-1:0] limit = timeout_limit(watchdog_clock_select, timeout_select);
  wire [`WDT_CNT_W-1:0] last_count = limit - `WDT_CNT_ONE;
  wire windowed = window_enable && !on_lpo;
  wire in_window = (count >= window_open(limit));

  // Counter step: bus clock pauses when halted, low-power clock waits for a tick
  // Only the bus mode pause is visible here; the slow-mode zeroing sits
  // in the counter process below.
  wire step = enabled && !fired && !halted && (on_lpo ? lpo_tick : 1'b1);

  // A key write before the window opens counts as premature
  // Either key counts, so a lone second key cannot slip in early
  wire early = windowed && (key_first || key_second) && !in_window;

  // Service completes on the second key after the first, inside any window
  wire serviced = key_second && key_armed && !early;

  // Overflow is the step that would carry the counter to the limit
  // A service that lands on the overflow cycle wins: software met the deadline
  wire overflow = step && (count == last_count) && !serviced;

  // Any fault asks for one reset; a disabled watchdog asks for none
  // fired blocks a second request while the system reset is on its way
  wire fault = enabled && !fired && (key_bad || early || overflow);

  // Write-once option registers; reset values pick low-power clock, longest timeout
  // Each register has its own lock flag, so locking one leaves the other open
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timeout_select <= `WDT_TSEL_RST;
      so1_locked <= 1'b0;
    end else if (wr_so1 && !so1_locked) begin
      timeout_select <= wdata_i[`WDT_TSEL_HI:`WDT_TSEL_LO];
      so1_locked <= 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      watchdog_clock_select <= `WDT_CLKS_RST;
      window_enable <= `WDT_WIN_RST;
      so2_locked <= 1'b0;
    end else if (wr_so2 && !so2_locked) begin
      watchdog_clock_select <= wdata_i[`WDT_CLKS_BIT];
      window_enable <= wdata_i[`WDT_WIN_BIT];
      so2_locked <= 1'b1;
    end
  end

  // First option write restarts the count so it runs on the new settings
  wire opt_init = (wr_so1 && !so1_locked) || (wr_so2 && !so2_locked);

  // Timeout counter
  // Service and option init win over a slow-clock halt; all three mean zero anyway
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= `WDT_CNT_ZERO;
    end else if (opt_init || serviced) begin
      count <= `WDT_CNT_ZERO;
    end else if (on_lpo && halted) begin
      count <= `WDT_CNT_ZERO;
    end else if (step && !overflow) begin
      count <= count + `WDT_CNT_ONE;
    end
  end

  // Key sequence: first key arms, second key services, anything else disarms
  // An early key never arms, so it cannot pair after the reset it asked for
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_armed <= 1'b0;
    end else if (opt_init) begin
      key_armed <= 1'b0;
    end else if (key_first && !early) begin
      key_armed <= 1'b1;
    end else if (wr_rss) begin
      key_armed <= 1'b0;
    end
  end

  // Reset request: one cycle, then quiet until the system reset comes back
  // Registered, so the reset controller sees a clean glitch-free pulse
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdt_reset_req_o <= 1'b0;
      fired <= 1'b0;
    end else begin
      wdt_reset_req_o <= fault;
      if (fault)
        fired <= 1'b1;
    end
  end

  // Reset-source record survives the system reset; only power-on clears it.
  // A later request from elsewhere cannot be seen here, so the bit stays set
  // until power is cycled.
  always @(posedge clk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      wdt_caused <= 1'b0;
    end else if (fault) begin
      wdt_caused <= 1'b1;
    end
  end

  // Power-on flag: set by power-on, dropped once a watchdog reset occurs
  always @(posedge clk_i or negedge por_b_i) begin
    if (!por_b_i) begin
      por_seen <= 1'b1;
    end else if (fault) begin
      por_seen <= 1'b0;
    end
  end

  // Read mux; writes to the status address change what it shows only through the fault they may raise
  // Counter reads give the top byte only: enough to watch progress
  reg [DW-1:0] next_rdata;

  always @* begin
    next_rdata = DZERO;
    if (addr_i == `WDT_ADDR_RSS) begin
      next_rdata[`WDT_RSS_POR_BIT] = por_seen;
      next_rdata[`WDT_RSS_WDT_BIT] = wdt_caused;
    end else if (addr_i == `WDT_ADDR_SO1) begin
      next_rdata[`WDT_TSEL_HI:`WDT_TSEL_LO] = timeout_select;
    end else if (addr_i == `WDT_ADDR_SO2) begin
      next_rdata[`WDT_CLKS_BIT] = watchdog_clock_select;
      next_rdata[`WDT_WIN_BIT] = window_enable;
    end else if (addr_i == `WDT_ADDR_CNT) begin
      next_rdata = count[`WDT_CNT_W-1:`WDT_CNT_W-DW];
    end else begin
      next_rdata = DZERO; // Unmapped reads return zero
    end
  end

  // Read data stands one cycle after the strobe and is zero otherwise
  // Zero between reads keeps stale values off a shared read bus
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= DZERO;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= DZERO;
    end
  end

endmodule
`default_nettype wire

// [wdt_props.sv]
// Port-level assertions for the windowed watchdog.
// Assumes one bus clock and shadows the timeout and clock select option fields.
`timescale 1ns/1ps
`default_nettype none
module wdt_props (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic stop_i,
  input wire logic debug_i,
  input wire logic wdt_reset_req_o
);
  logic [1:0] tsel;
  logic lk1, lk2, clks, fired, wd_seen;
  // Shadow options; only the first write after reset counts
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tsel <= 2'h3;
      {lk1, lk2, clks, fired} <= 4'h0;
    end else begin
      if (wr_i && addr_i == 4'h1 && !lk1) begin
        tsel <= wdata_i[7:6];
        lk1 <= 1'b1;
      end
      if (wr_i && addr_i == 4'h2 && !lk2) begin
        clks <= wdata_i[7];
        lk2 <= 1'b1;
      end
      if (wdt_reset_req_o) fired <= 1'b1;
    end
  end
  // Watchdog source flag survives system resets, so only power-on clears it
  always_ff @(posedge clk_i or negedge por_b_i) begin
    if (!por_b_i) wd_seen <= 1'b0;
    else if (wdt_reset_req_o) wd_seen <= 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence bad_wr;
    wr_i && addr_i == 4'h0 && wdata_i != 8'h55 && wdata_i != 8'haa;
  endsequence
  // Halt long enough to pass the two-flop synchroniser
  sequence lpo_halt;
    (!clks && (stop_i || debug_i) && !wr_i)[*5];
  endsequence
  req_one_a: assert property (wdt_reset_req_o |=> !wdt_reset_req_o)
    else $error("reset request longer than one cycle");
  bad_key_a: assert property (bad_wr ##0 (tsel != 2'h0 && !fired && !wdt_reset_req_o)
    |=> wdt_reset_req_o) else $error("wrong key without reset");
  off_quiet_a: assert property (tsel == 2'h0 |=> !wdt_reset_req_o)
    else $error("reset while disabled");
  key_ok_a: assert property (wr_i && addr_i == 4'h0 && !clks &&
    (wdata_i == 8'h55 || wdata_i == 8'haa) |=> !wdt_reset_req_o) else $error("key reset");
  opt_read_a: assert property (rd_i && addr_i == 4'h1
    |=> rdata_o[7:6] == $past(tsel)) else $error("timeout select not locked");
  rss_flag_a: assert property (rd_i && addr_i == 4'h0
    |=> rdata_o[5] == $past(wd_seen || wdt_reset_req_o)) else $error("watchdog source bit wrong");
  lpo_halt_a: assert property (lpo_halt |=> !wdt_reset_req_o)
    else $error("reset while halted on slow clock");
  boot_quiet_a: assert property ($rose(rst_b_i) ##0 (!wr_i)[*3]
    |=> !wdt_reset_req_o) else $error("reset request right after reset");
endmodule
bind wdt_watchdog_timer wdt_props wdt_props_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .por_b_i(por_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .stop_i(stop_i), .debug_i(debug_i), .wdt_reset_req_o(wdt_reset_req_o));
`default_nettype wire

// [wdt_watchdog_timer_tb.sv]
// Self-checking bench for the windowed watchdog through its register port.
// Assumes the bound checker; the slow tick is cut to 4 bus cycles.
`timescale 1ns/1ps
`default_nettype none
module wdt_watchdog_timer_tb;
  logic clk_i = 0, rst_b_i = 0, por_b_i = 0, wr_i = 0, rd_i = 0, stop_i = 0, debug_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, d;
  wire [7:0] rdata_o;
  wire wdt_reset_req_o;
  int fail_count = 0, num_checks = 0;
  // 40 MHz bus clock
  always #12.5 clk_i = ~clk_i;
  wdt_watchdog_timer #(.LPO_DIV(4)) wdt_watchdog_timer_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .por_b_i(por_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .stop_i(stop_i), .debug_i(debug_i), .wdt_reset_req_o(wdt_reset_req_o));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  // Power-on also clears the watchdog source flag
  task rst(input logic p);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    por_b_i <= ~p;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    por_b_i <= 1'b1;
  endtask
  // Request expected (e) or absent within hi cycles, never before lo
  task wq(input int lo, input int hi, input logic e);
    int n;
    n = 0;
    while (wdt_reset_req_o !== 1'b1 && n < hi) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({6'h0, n >= lo, wdt_reset_req_o}, {6'h0, 1'b1, e});
  endtask
  task wrap_up();
    $display("checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    int e;
    rst(1'b1);
    rd(4'h1);
    chk(d, 8'hc0);
    rd(4'h2);
    chk(d, 8'h00);
    rd(4'h0);
    chk(d & 8'ha0, 8'h80);
    wq(4070, 4110, 1'b1);
    for (int i = 1; i < 4; i++) begin
      rst(1'b0);
      wr(4'h1, {i[1:0], 6'h00});
      e = 4 << (i == 1 ? 5 : i == 2 ? 8 : 10);
      wq(e - 8, e + 8, 1'b1);
    end
    rst(1'b0);
    rd(4'h0);
    chk(d & 8'ha0, 8'h20);
    wr(4'h2, 8'h40);
    wr(4'h1, 8'h40);
    wr(4'h0, 8'h55);
    wr(4'h0, 8'haa);
    wq(100, 100, 1'b0);
    wr(4'h0, 8'h55);
    wr(4'h0, 8'haa);
    wq(100, 100, 1'b0);
    rd(4'h0);
    chk(d & 8'ha0, 8'h20);
    wr(4'h1, 8'h00);
    rd(4'h1);
    chk(d, 8'h40);
    wq(8, 36, 1'b1);
    rst(1'b0);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h12);
    wq(300, 300, 1'b0);
    rst(1'b0);
    wr(4'h0, 8'h12);
    wq(0, 0, 1'b1);
    rst(1'b0);
    wr(4'h2, 8'h80);
    wr(4'h1, 8'h40);
    wq(8186, 8198, 1'b1);
    // Window mode: premature, just before opening, then inside the window
    for (int k = 0; k < 3; k++) begin
      rst(1'b0);
      wr(4'h2, 8'hc0);
      wr(4'h1, 8'h40);
      repeat (k == 0 ? 0 : k == 1 ? 6100 : 6160) @(posedge clk_i);
      wr(4'h0, 8'h55);
      if (k < 2) wq(0, 0, 1'b1);
      else wr(4'h0, 8'haa);
    end
    wq(2100, 2100, 1'b0);
    rst(1'b0);
    wr(4'h2, 8'h80);
    wr(4'h1, 8'h40);
    repeat (4000) @(posedge clk_i);
    stop_i <= 1'b1;
    wq(9000, 9000, 1'b0);
    rd(4'h3);
    chk(d, 8'h01);
    @(posedge clk_i);
    stop_i <= 1'b0;
    wq(4170, 4215, 1'b1);
    rst(1'b0);
    wr(4'h1, 8'h40);
    repeat (100) @(posedge clk_i);
    debug_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    debug_i <= 1'b0;
    wq(120, 140, 1'b1);
    wrap_up();
  end
  // Hang guard, well beyond the roughly 50k cycles the sequence needs
  initial begin
    repeat (65000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
